// >>> hdl/cma_top.sv
// core memory control and multiplexer: arbitration, cycle sequencing, parity
// assumes user inputs synchronous to clk and held stable while requesting
// Operation
// - simultaneous requests: bulk controller granted first, processor user last
// - priority order: bulk, channel two, channel three, processor user
// - running cycle completes; later higher request waits for next arbitration
// - after arbitration issue start pulse and load winner address
// - write winner gets grant with the start pulse and address, before data is taken
// - every cycle first clears addressed word; ones appear on sense
// - data register loads sensed word on read, user data on write
// - on write the sensed word is discarded entirely
// - second half stores data register back into addressed word
// - store half drives only positions holding one
// - check parity on reads, generate parity on writes, never reversed
// - write parity computed from user data, loaded with data word
// - word is 24 data bits plus parity, total ones odd
// - even ones on any user's read raises parity_err
// - non-processor write parity mismatch flags transmission error, word still stored
// - read asserts data ready when word may be taken
// - release pulse marks end of every memory cycle
// - every access is full clear then store cycle
// - one memory cycle lasts 1.6 microseconds
`timescale 1ns/10ps
module cma_top
(
  input wire logic clk,
  input wire logic srst,
  input cma_pkg::cma_req_s usr_req [cma_pkg::NUM_USERS],
  output cma_pkg::cma_ack_s usr_ack [cma_pkg::NUM_USERS],
  output logic [cma_pkg::DATA_W-1:0] rd_data,
  output logic parity_err,
  output logic mem_release,
  output cma_pkg::cma_mem_s mem,
  input wire logic [cma_pkg::WORD_W-1:0] sense
);
  import cma_pkg::*;

  cma_state_e state_reg;
  cma_state_e state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [USR_W-1:0] act_usr_reg;
  logic act_wr_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [WORD_W-1:0] data_reg;
  logic start_reg;
  logic [NUM_USERS-1:0] grant_reg;
  logic [NUM_USERS-1:0] ready_reg;
  logic [NUM_USERS-1:0] xerr_reg;
  logic perr_reg;
  logic rel_reg;

  // arbitration; only looked at in idle, so a running cycle is never pre-empted
  logic [NUM_USERS-1:0] req_vec;
  wire win_any;
  wire [USR_W-1:0] win_idx;
  wire take;
  wire clear_end;
  wire store_end;
  wire [DATA_W-1:0] act_data;
  wire act_par;
  wire gen_par;
  wire sense_odd;
  wire [NUM_USERS-1:0] act_onehot;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_USERS; gi++)
    begin : g_usr
      assign req_vec[gi] = usr_req[gi].req;
      assign act_onehot[gi] = (act_usr_reg == USR_W'(gi));
      assign usr_ack[gi].grant = grant_reg[gi];
      assign usr_ack[gi].data_ready = ready_reg[gi];
      assign usr_ack[gi].xmit_err = xerr_reg[gi];
    end
  endgenerate

  assign win_any = |req_vec;
  assign win_idx = req_vec[USR_BULK] ? USR_BULK :
                   req_vec[USR_CH2] ? USR_CH2 :
                   req_vec[USR_CH3] ? USR_CH3 :
                   USR_PROC;
  assign take = (state_reg == ST_IDLE) && win_any;
  assign clear_end = (state_reg == ST_CLEAR) && (cnt_reg == CLEAR_LAST);
  assign store_end = (state_reg == ST_STORE) && (cnt_reg == CYCLE_LAST);

  // write data taken at end of clear, the user holds it while requesting
  assign act_data = usr_req[act_usr_reg].data;
  assign act_par = usr_req[act_usr_reg].par;
  assign gen_par = ~(^act_data);
  assign sense_odd = ^sense;

  // sequencing: clear half always followed by store half, no clear-only cycle
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take)
        begin
          state_next = ST_CLEAR;
          cnt_next = CNT_FIRST;
        end
      end
      ST_CLEAR:
      begin
        cnt_next = cnt_reg + CNT_FIRST;
        if (clear_end)
          state_next = ST_STORE;
      end
      ST_STORE:
      begin
        cnt_next = cnt_reg + CNT_FIRST;
        if (store_end)
        begin
          state_next = ST_IDLE;
          cnt_next = CNT_ZERO;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        cnt_next = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // winner latched at the start pulse
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      act_usr_reg <= USR_BULK;
      act_wr_reg <= 1'b0;
      addr_reg <= '0;
    end
    else if (take)
    begin
      act_usr_reg <= win_idx;
      act_wr_reg <= usr_req[win_idx].wr;
      addr_reg <= usr_req[win_idx].addr;
    end
  end

  // grant only on writes, in the same cycle as the start pulse and first clear clock
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      start_reg <= 1'b0;
      grant_reg <= '0;
    end
    else
    begin
      start_reg <= take;
      grant_reg <= (take && usr_req[win_idx].wr) ? (NUM_USERS'(1) << win_idx) : '0;
    end
  end

  // data register: sensed word on read, user word plus generated parity on write
  always_ff @(posedge clk)
  begin
    if (srst)
      data_reg <= '0;
    else if (clear_end)
      data_reg <= act_wr_reg ? {gen_par, act_data} : sense;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ready_reg <= '0;
      xerr_reg <= '0;
      perr_reg <= 1'b0;
      rel_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= (clear_end && !act_wr_reg) ? act_onehot : '0;
      xerr_reg <= (clear_end && act_wr_reg && (act_usr_reg != USR_PROC) &&
                   (act_par != gen_par)) ? act_onehot : '0;
      perr_reg <= clear_end && !act_wr_reg && !sense_odd;
      rel_reg <= store_end;
    end
  end

  assign rd_data = data_reg[DATA_W-1:0];
  assign parity_err = perr_reg;
  assign mem_release = rel_reg;
  assign mem.start = start_reg;
  assign mem.addr = addr_reg;
  assign mem.clear = (state_reg == ST_CLEAR);
  // zero positions stay undriven so the cleared core keeps its zero
  assign mem.drive = (state_reg == ST_STORE) ? data_reg : '0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_PRIO_BULK:
    assert property (take && req_vec[USR_BULK] && req_vec[USR_PROC] |=> act_usr_reg == USR_BULK)
    else $error("bulk controller lost arbitration to processor user");

  AST_PRIO_ORDER:
    assert property (take && !req_vec[USR_BULK] && req_vec[USR_CH2] && req_vec[USR_CH3]
                     |=> act_usr_reg == USR_CH2)
    else $error("channel two not preferred over channel three");

  AST_NO_PREEMPT:
    assert property ((state_reg != ST_IDLE) |=> $stable(act_usr_reg) && $stable(addr_reg))
    else $error("running cycle changed owner or address");

  AST_START_CLEAR:
    assert property ($rose(mem.start) |-> mem.clear && mem.addr == $past(usr_req[win_idx].addr))
    else $error("start pulse without clear or wrong address");

  AST_GRANT_FIRST:
    assert property (|grant_reg |-> mem.start ##1 mem.clear)
    else $error("grant not aligned ahead of the write cycle");

  AST_FULL_CYCLE:
    assert property ($fell(mem.clear) |-> (state_reg == ST_STORE) [*8])
    else $error("clear phase not followed by store phase");

  AST_HALF_TIME:
    assert property ($rose(mem.start) |-> ##199 (state_reg == ST_STORE) ##200 mem_release)
    else $error("memory cycle length wrong");

  AST_DRIVE_ONES:
    assert property ((mem.drive & ~data_reg) == '0 && (mem.clear -> mem.drive == '0))
    else $error("drive on a zero bit or during clear");

  AST_WRITE_PAR:
    assert property ((state_reg == ST_STORE) && act_wr_reg |-> ^data_reg)
    else $error("written word does not hold odd parity");

  AST_READ_ONLY_FLAGS:
    assert property (parity_err || (|ready_reg) |-> !act_wr_reg && $past(mem.clear))
    else $error("read flag raised on a write cycle");

  AST_XERR_NOT_PROC:
    assert property (|xerr_reg |-> act_wr_reg && act_usr_reg != USR_PROC)
    else $error("transmission error flagged for processor or read");

  AST_RESET_IDLE:
    assert property ($past(srst) |-> state_reg == ST_IDLE && !mem_release && !parity_err)
    else $error("not idle after reset");

  AST_GRANT_WRITE:
    assert property (|grant_reg |-> act_wr_reg && grant_reg == act_onehot)
    else $error("grant on a read or to the wrong user");

  AST_READY_OWNER:
    assert property (|ready_reg |-> ready_reg == act_onehot &&
                     rd_data == $past(sense[DATA_W-1:0]))
    else $error("data ready to wrong user or word not loaded");

  AST_READ_LOAD:
    assert property (clear_end && !act_wr_reg |=> data_reg == $past(sense))
    else $error("read did not load the sensed word");

  AST_WRITE_DISCARD:
    assert property (clear_end && act_wr_reg
                     |=> data_reg[DATA_W-1:0] == $past(usr_req[act_usr_reg].data))
    else $error("write data register not loaded from user");

  AST_PERR_EVEN:
    assert property (clear_end && !act_wr_reg && !(^sense) |=> parity_err)
    else $error("even word read without parity error");

  AST_XERR_BAD:
    assert property (clear_end && act_wr_reg && act_usr_reg != USR_PROC &&
                     (usr_req[act_usr_reg].par == ^usr_req[act_usr_reg].data)
                     |=> xerr_reg == act_onehot)
    else $error("bad sent parity not flagged to its user");

  AST_START_PULSE:
    assert property (mem.start |=> !mem.start && mem.clear)
    else $error("start not a single pulse ahead of clear");

  AST_CLEAR_FIRST:
    assert property ($rose(mem.clear) |-> mem.start && mem.drive == '0)
    else $error("clear phase not opening the cycle");

  AST_DRIVE_STORE:
    assert property (state_reg == ST_STORE |-> mem.drive == data_reg)
    else $error("store half not driving the data register");

  AST_RELEASE_IDLE:
    assert property (mem_release |-> state_reg == ST_IDLE && !mem.clear && !mem.start)
    else $error("release not at the end of the cycle");

  AST_IDLE_QUIET:
    assert property (state_reg == ST_IDLE |-> !mem.clear && mem.drive == '0 &&
                     grant_reg == '0 && ready_reg == '0)
    else $error("idle controller shows cycle activity");

endmodule : cma_top

// >>> hdl/cma_pkg.sv
// constants, types and timing for the core memory control/arbiter
// assumes a 250 MHz clock; the memory stack itself sits outside
package cma_pkg;

  localparam int NUM_USERS = 4;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 24;
  localparam int WORD_W = 25;
  localparam int PAR_BIT = 24;
  localparam int USR_W = 2;

  // user slots, lower index wins arbitration
  localparam logic [USR_W-1:0] USR_BULK = 2'h0;
  localparam logic [USR_W-1:0] USR_CH2 = 2'h1;
  localparam logic [USR_W-1:0] USR_CH3 = 2'h2;
  localparam logic [USR_W-1:0] USR_PROC = 2'h3;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int CYCLE_TIME_PS = 1600000;
  localparam int CYCLE_CLKS = CYCLE_TIME_PS / CLK_PERIOD_PS;
  localparam int HALF_CLKS = CYCLE_CLKS / 2;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_FIRST = 9'h001;
  localparam logic [CNT_W-1:0] CLEAR_LAST = CNT_W'(HALF_CLKS - 1);
  localparam logic [CNT_W-1:0] CYCLE_LAST = CNT_W'(CYCLE_CLKS - 1);

  typedef struct packed {
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic par;
  } cma_req_s;

  typedef struct packed {
    logic grant;
    logic data_ready;
    logic xmit_err;
  } cma_ack_s;

  typedef struct packed {
    logic start;
    logic [ADDR_W-1:0] addr;
    logic clear;
    logic [WORD_W-1:0] drive;
  } cma_mem_s;

  typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_STORE} cma_state_e;

endpackage : cma_pkg

// >>> verif/cma_core_model.sv
// behavioural core stack facing the control/arbiter's memory port
// assumes addresses differ in their low four bits; reads destroy the word
`timescale 1ns/10ps
module cma_core_model
(
  input wire logic clk,
  input cma_pkg::cma_mem_s mem,
  input wire logic flip,
  output logic [cma_pkg::WORD_W-1:0] sense
);
  import cma_pkg::*;
  logic [WORD_W-1:0] core_reg [16];
  logic [WORD_W-1:0] sensed_reg = '0;
  logic [3:0] adr_reg = 4'h0;

  initial
    for (int i = 0; i < 16; i++)
      core_reg[i] = '0;

  always @(posedge clk)
  begin
    if (mem.start)
    begin
      adr_reg <= mem.addr[3:0];
      sensed_reg <= core_reg[mem.addr[3:0]];
      core_reg[mem.addr[3:0]] <= '0;
    end
    else if (!mem.clear && mem.drive != '0)
      core_reg[adr_reg] <= core_reg[adr_reg] | mem.drive;
  end

  // outside the clear half the amplifiers show nothing useful
  assign sense = mem.clear ? (sensed_reg ^ WORD_W'(flip)) : ~sensed_reg;
endmodule : cma_core_model

// >>> verif/tb_top.sv
// self-checking bench for the core memory control/arbiter
// assumes the core stack model on the memory port
`timescale 1ns/10ps
module tb_top;
  import cma_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic flip = 1'b0;
  cma_req_s usr_req [NUM_USERS];
  cma_ack_s usr_ack [NUM_USERS];
  logic [DATA_W-1:0] rd_data;
  logic parity_err;
  logic mem_release;
  cma_mem_s mem;
  logic [WORD_W-1:0] sense;
  logic [DATA_W-1:0] wdat [NUM_USERS];
  logic [27:0] exp_q [$];
  logic [27:0] obs = '0;
  logic [ADDR_W-1:0] adr = '0;
  logic [3:0] wown = 4'h0;
  logic [15:0] rnd = 16'h005b;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int cnt = 0;

  always #2 clk = ~clk;

  cma_top dut (.clk(clk), .srst(srst), .usr_req(usr_req), .usr_ack(usr_ack), .rd_data(rd_data),
    .parity_err(parity_err), .mem_release(mem_release), .mem(mem), .sense(sense));
  cma_core_model core (.clk(clk), .mem(mem), .flip(flip), .sense(sense));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // note layout: write, user, error flag, read word
  task automatic ask(input int u, input logic wr, input logic badp, input logic e,
    input logic [DATA_W-1:0] ed);
    rnd = lfsr(rnd);
    usr_req[u] = {1'b1, wr, ADDR_W'(u), {rnd[7:0], rnd}, ~^{rnd[7:0], rnd} ^ badp};
    if (wr)
      wdat[u] = {rnd[7:0], rnd};
    exp_q.push_back({wr, 2'(u), e, wr ? 24'h0 : ed});
  endtask : ask

  task automatic sync;
    wait (exp_q.size() == 0);
    @(posedge clk);
    #1;
  endtask : sync

  initial
  begin
    for (int i = 0; i < NUM_USERS; i++)
      usr_req[i] = '0;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    check({mem.start, mem.clear, mem.drive != '0, parity_err, mem_release}, 0);
    for (int u = 0; u < NUM_USERS; u++)
    begin
      sync;
      ask(u, 1'b1, u[0], u == 1, '0);
    end
    sync;
    $display("test writes done");
    for (int u = 0; u < NUM_USERS; u++)
      ask(u, 1'b0, 1'b0, 1'b0, wdat[u]);
    sync;
    $display("test simultaneous reads done");
    ask(3, 1'b0, 1'b0, 1'b0, wdat[3]);
    repeat (20) @(posedge clk);
    #1;
    ask(0, 1'b0, 1'b0, 1'b0, wdat[0]);
    sync;
    $display("test no preemption done");
    flip = 1'b1;
    ask(2, 1'b0, 1'b0, 1'b1, wdat[2] ^ 24'h1);
    sync;
    flip = 1'b0;
    ask(2, 1'b0, 1'b0, 1'b1, wdat[2] ^ 24'h1);
    sync;
    $display("test parity fault done");
    give_verdict;
  end

  // watcher: gathers one cycle's answers and drops each user's request when served
  always @(posedge clk)
  begin
    #1;
    if (!srst)
    begin
      cnt++;
      if (mem.start === 1'b1)
      begin
        cnt = 0;
        obs = '0;
        adr = mem.addr;
      end
      for (int i = 0; i < NUM_USERS; i++)
      begin
        if (usr_ack[i].grant === 1'b1)
          obs[27:25] = {1'b1, 2'(i)};
        if (usr_ack[i].data_ready === 1'b1)
          obs[26:0] = {2'(i), parity_err, rd_data};
        if (usr_ack[i].xmit_err === 1'b1)
          obs[24] = 1'b1;
        if (usr_ack[i].data_ready === 1'b1 || (wown[i] && mem.clear !== 1'b1))
        begin
          usr_req[i].req = 1'b0;
          wown[i] = 1'b0;
        end
        if (usr_ack[i].grant === 1'b1)
          wown[i] = 1'b1;
      end
      // a parity error on a read lands in the flag bit and is compared with the expected error flag
      if (parity_err === 1'b1)
        obs[24] = 1'b1;
      if (mem_release === 1'b1)
      begin
        check(obs, exp_q.pop_front());
        check(adr, obs[26:25]);
        check(cnt, 399);
      end
    end
  end

  // limit well above twelve cycles of 400 clocks
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      fail_count++;
      give_verdict;
    end
  end
endmodule : tb_top
